// file: hdl/cfe_pkg.sv
// constants, register map and carrier types of the front-end control block
package cfe_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ        = 40_000_000;
   localparam int WD_PERIOD_MS  = 212;
   // longest time: rounds down
   localparam int WD_PERIOD_CYC = WD_PERIOD_MS * (CLK_HZ / 1000);
   localparam int WD_PULSE_US   = 967;
   // pulse length: rounds up
   localparam int WD_PULSE_CYC  = (WD_PULSE_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int WD_CNT_W      = 24;
   localparam int PULSE_CNT_W   = 16;

   // ------------------------------------------------------------
   // bus geometry and register indexes (byte address = 4 * index)
   // ------------------------------------------------------------
   localparam int          ADR_W                 = 18;
   localparam logic [15:0] IDX_HDR_MODE          = 16'hf092;
   localparam logic [15:0] IDX_HDR_MINUTES       = 16'hf093;
   localparam logic [15:0] IDX_HDR_SECONDS       = 16'hf09a;
   localparam logic [15:0] IDX_HDR_FRAME         = 16'hf09b;
   localparam logic [15:0] IDX_FRONT_END_CONTROL = 16'hf0bb;
   localparam logic [15:0] IDX_INTERRUPT_FLAG    = 16'hf0c0;
   localparam logic [15:0] IDX_READ_STATUS       = 16'hf0c3;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int         ST_ACTIVE_BIT   = 7;
   localparam int         ST_QRDY_BIT     = 5;
   localparam int         ST_HDR_BIT      = 4;
   localparam int         ST_SEARCH_BIT   = 0;
   localparam int         INTR_READY_BIT  = 0;
   localparam logic [7:0] CTL_RESET       = 8'h03;

   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic forced_frame_end;
      logic sync_search_trigger;
      logic uart_break;
      logic watchdog_service;
      logic audio_path_enable;
      logic audio_mode_select;
      logic sync_stop_select;
      logic data_flow_stop;
   } cfe_ctrl_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] minutes;
      logic [7:0] seconds;
      logic [7:0] frame;
   } cfe_hdr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } cfe_byte_t;

endpackage

// file: hdl/cfe_front_end_ctrl.sv
// front-end control register, data flow gating, sync search and watchdog
// Operation
// - data mode, stop bit 0, synchronous: start storing at next sync pattern
// - stop bit 1: halt incoming data just before next sync pattern
// - any reset forces the stop bit to 1
// - sync/async selection only matters in data mode
// - sync selection 0 stops data at once, mid-frame
// - sync selection 1 starts and stops only at sync patterns
// - audio mode bit 0 means data mode; cleared on reset
// - audio mode bit 1 selects audio mode and shifts the bit clock
// - combined ready follows header valid in data mode, Q ready in audio
// - audio enable acts as inverted stop bit; no async stop in audio
// - audio enable 0 stops audio at next F1 C-flag; cleared on reset
// - audio enable 1 starts audio storage after next F1 C-flag
// - firmware pulses service bit within 212 ms or watchdog resets chip
// - watchdog reset pulse lasts 967 microseconds
// - service bit held at 1 disables the watchdog
// - break bit holds the UART transmit output high
// - sync-search bit pulsed high then low starts sync search
// - sync found by search makes header registers valid
// - forced frame-end pulse resets frame counters to beginning of frame
// - forced frame-end acts only while data path is inactive
// - while forced frame-end is set nothing is stored
// - data path active flag is high for the whole transfer
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
module cfe_front_end_ctrl #(
   parameter int WD_PERIOD_CYC = cfe_pkg::WD_PERIOD_CYC,
   parameter int WD_PULSE_CYC  = cfe_pkg::WD_PULSE_CYC
) (
   // clock and reset
   input  wire  logic                        CLK,
   input  wire  logic                        RESET,
   // wishbone slave
   input  wire  logic                        CYC_I,
   input  wire  logic                        STB_I,
   input  wire  logic                        WE_I,
   input  wire  logic [cfe_pkg::ADR_W-1:0]   ADR_I,
   input  wire  logic [3:0]                  SEL_I,
   input  wire  logic [31:0]                 DAT_I,
   output logic       [31:0]                 DAT_O,
   output logic                              ACK_O,
   // decoder stream
   input  wire  logic                        SYNC_DET,
   input  wire  logic                        F1_CFLAG,
   input  wire  cfe_pkg::cfe_byte_t          DATA_IN,
   input  wire  cfe_pkg::cfe_byte_t          SUB_IN,
   input  wire  cfe_pkg::cfe_hdr_t           HDR_IN,
   input  wire  logic                        Q_FRAME_READY,
   // buffer manager side
   output cfe_pkg::cfe_byte_t                BUF_DATA,
   output cfe_pkg::cfe_byte_t                BUF_SUB,
   output logic                              FRAME_RESET,
   // status and miscellaneous
   output logic                              DATA_ACTIVE,
   output logic                              BIT_CLK_SHIFT,
   output logic                              SEARCH_ACTIVE,
   output logic                              COMBINED_READY,
   input  wire  logic                        UART_TX_IN,
   output logic                              UART_TX_OUT,
   output logic                              CHIP_RESET
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {WD_RUN, WD_FIRE} cfe_wd_state_t;

   cfe_pkg::cfe_ctrl_t   ctrl,        next_ctrl;
   cfe_pkg::cfe_ctrl_t   ctrl_prev;
   logic                 ack,         next_ack;
   logic [31:0]          rdata,       next_rdata;
   logic                 active,      next_active;
   logic                 searching,   next_searching;
   logic                 hdr_valid,   next_hdr_valid;
   cfe_pkg::cfe_hdr_t    hdr,         next_hdr;
   cfe_pkg::cfe_byte_t   buf_data,    next_buf_data;
   cfe_pkg::cfe_byte_t   buf_sub,     next_buf_sub;
   logic                 frame_rst,   next_frame_rst;
   logic                 tx_out,      next_tx_out;
   logic                 ready,       next_ready;
   cfe_wd_state_t        wd_state,    next_wd_state;
   logic [cfe_pkg::WD_CNT_W-1:0]    wd_cnt,    next_wd_cnt;
   logic [cfe_pkg::PULSE_CNT_W-1:0] pulse_cnt, next_pulse_cnt;
   logic                 soft_rst;
   logic                 req;
   logic [15:0]          idx;
   logic                 fell_search;
   logic                 fell_ffe;
   logic                 fell_wd;
   logic                 hdr_read;
   logic                 chip_rst,    next_chip_rst;

   // word index decode, shared by write, read and clear-on-read
   function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_idx);
      hit = (a == reg_idx);
   endfunction

   // watchdog reset is a reset condition for the control state
   assign soft_rst    = RESET || (wd_state == WD_FIRE);
   assign req         = CYC_I && STB_I;
   assign idx         = ADR_I[cfe_pkg::ADR_W-1:2];
   assign fell_search = ctrl_prev.sync_search_trigger && !ctrl.sync_search_trigger;
   assign fell_ffe    = ctrl_prev.forced_frame_end && !ctrl.forced_frame_end;
   assign fell_wd     = ctrl_prev.watchdog_service && !ctrl.watchdog_service;
   assign hdr_read    = ack && !WE_I && (hit(idx, cfe_pkg::IDX_HDR_MODE) || hit(idx, cfe_pkg::IDX_HDR_MINUTES) ||
                        hit(idx, cfe_pkg::IDX_HDR_SECONDS) || hit(idx, cfe_pkg::IDX_HDR_FRAME));

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   always_comb begin
      next_ack   = req && !ack;
      next_ctrl  = ctrl;
      next_rdata = 32'h0000_0000;
      if (req && !ack && !WE_I) begin
         if (hit(idx, cfe_pkg::IDX_FRONT_END_CONTROL)) begin
            next_rdata[7:0] = ctrl;
         end else if (hit(idx, cfe_pkg::IDX_READ_STATUS)) begin
            next_rdata[cfe_pkg::ST_ACTIVE_BIT] = active;
            next_rdata[cfe_pkg::ST_QRDY_BIT]   = Q_FRAME_READY;
            next_rdata[cfe_pkg::ST_HDR_BIT]    = hdr_valid;
            next_rdata[cfe_pkg::ST_SEARCH_BIT] = searching;
         end else if (hit(idx, cfe_pkg::IDX_INTERRUPT_FLAG)) begin
            next_rdata[cfe_pkg::INTR_READY_BIT] = ready;
         end else if (hit(idx, cfe_pkg::IDX_HDR_MODE)) begin
            next_rdata[7:0] = hdr.mode;
         end else if (hit(idx, cfe_pkg::IDX_HDR_MINUTES)) begin
            next_rdata[7:0] = hdr.minutes;
         end else if (hit(idx, cfe_pkg::IDX_HDR_SECONDS)) begin
            next_rdata[7:0] = hdr.seconds;
         end else if (hit(idx, cfe_pkg::IDX_HDR_FRAME)) begin
            next_rdata[7:0] = hdr.frame;
         end
      end
      // write lands at the edge where the master sees ack
      if (ack && WE_I && SEL_I[0] && hit(idx, cfe_pkg::IDX_FRONT_END_CONTROL)) begin
         next_ctrl = cfe_pkg::cfe_ctrl_t'(DAT_I[7:0]);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ack   <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
      if (soft_rst) begin
         ctrl      <= cfe_pkg::cfe_ctrl_t'(cfe_pkg::CTL_RESET);
         ctrl_prev <= cfe_pkg::cfe_ctrl_t'(cfe_pkg::CTL_RESET);
      end else begin
         ctrl      <= next_ctrl;
         ctrl_prev <= ctrl;
      end
   end

   // ------------------------------------------------------------
   // data flow gating
   // ------------------------------------------------------------
   always_comb begin
      next_active    = active;
      next_buf_data  = '0;
      next_buf_sub   = '0;
      next_frame_rst = 1'b0;
      if (!ctrl.audio_mode_select) begin
         if (!ctrl.sync_stop_select) begin
            next_active = 1'b0;
         end else if (SYNC_DET) begin
            next_active = !ctrl.data_flow_stop;
         end
      end else if (F1_CFLAG) begin
         next_active = ctrl.audio_path_enable;
      end
      if (active && !ctrl.forced_frame_end) begin
         next_buf_data = DATA_IN;
         next_buf_sub  = SUB_IN;
      end
      if (fell_ffe && !active) begin
         next_frame_rst = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (soft_rst) begin
         active    <= 1'b0;
         buf_data  <= '0;
         buf_sub   <= '0;
         frame_rst <= 1'b0;
      end else begin
         active    <= next_active;
         buf_data  <= next_buf_data;
         buf_sub   <= next_buf_sub;
         frame_rst <= next_frame_rst;
      end
   end

   // ------------------------------------------------------------
   // sync search and header capture
   // ------------------------------------------------------------
   always_comb begin
      next_searching = searching;
      next_hdr_valid = hdr_valid;
      next_hdr       = hdr;
      if (hdr_read) begin
         next_hdr_valid = 1'b0;
      end
      if (fell_search) begin
         next_searching = 1'b1;
      end else if (searching && SYNC_DET) begin
         next_searching = 1'b0;
         next_hdr_valid = 1'b1;
         next_hdr       = HDR_IN;
      end
      next_ready = ctrl.audio_mode_select ? Q_FRAME_READY : hdr_valid;
   end

   always_ff @(posedge CLK) begin
      if (soft_rst) begin
         searching <= 1'b0;
         hdr_valid <= 1'b0;
         hdr       <= '0;
         ready     <= 1'b0;
      end else begin
         searching <= next_searching;
         hdr_valid <= next_hdr_valid;
         hdr       <= next_hdr;
         ready     <= next_ready;
      end
   end

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   always_comb begin
      next_wd_state  = wd_state;
      next_wd_cnt    = wd_cnt;
      next_pulse_cnt = pulse_cnt;
      case (wd_state)
         WD_RUN: begin
            if (ctrl.watchdog_service || fell_wd) begin
               next_wd_cnt = '0;
            end else if (wd_cnt == cfe_pkg::WD_CNT_W'(WD_PERIOD_CYC - 1)) begin
               next_wd_state  = WD_FIRE;
               next_wd_cnt    = '0;
               next_pulse_cnt = '0;
            end else begin
               next_wd_cnt = wd_cnt + 1'b1;
            end
         end
         WD_FIRE: begin
            if (pulse_cnt == cfe_pkg::PULSE_CNT_W'(WD_PULSE_CYC - 1)) begin
               next_wd_state = WD_RUN;
            end else begin
               next_pulse_cnt = pulse_cnt + 1'b1;
            end
         end
         default: begin
            next_wd_state = WD_RUN;
         end
      endcase
      next_chip_rst = (next_wd_state == WD_FIRE);
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         wd_state  <= WD_RUN;
         wd_cnt    <= '0;
         pulse_cnt <= '0;
         chip_rst  <= 1'b0;
      end else begin
         chip_rst  <= next_chip_rst;
         wd_state  <= next_wd_state;
         wd_cnt    <= next_wd_cnt;
         pulse_cnt <= next_pulse_cnt;
      end
   end

   // ------------------------------------------------------------
   // uart break
   // ------------------------------------------------------------
   always_comb begin
      next_tx_out = ctrl.uart_break ? 1'b1 : UART_TX_IN;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         tx_out <= 1'b1;
      end else begin
         tx_out <= next_tx_out;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign DAT_O          = rdata;
   assign ACK_O          = ack;
   assign BUF_DATA       = buf_data;
   assign BUF_SUB        = buf_sub;
   assign FRAME_RESET    = frame_rst;
   assign DATA_ACTIVE    = active;
   assign BIT_CLK_SHIFT  = ctrl.audio_mode_select;
   assign SEARCH_ACTIVE  = searching;
   assign COMBINED_READY = ready;
   assign UART_TX_OUT    = tx_out;
   assign CHIP_RESET     = chip_rst;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   reset_state_a: assert property (disable iff (1'b0) RESET |=> ctrl.data_flow_stop && !ctrl.audio_mode_select
         && !ctrl.audio_path_enable && !DATA_ACTIVE)
      else $error("control bits not at reset values");
   sync_start_a: assert property (!active && !ctrl.audio_mode_select && ctrl.sync_stop_select && !ctrl.data_flow_stop
         && SYNC_DET && !soft_rst |=> DATA_ACTIVE)
      else $error("data flow did not start at sync");
   sync_stop_a: assert property (active && !ctrl.audio_mode_select && ctrl.data_flow_stop && SYNC_DET
         |=> !DATA_ACTIVE)
      else $error("data flow did not stop at sync");
   sync_hold_a: assert property (!ctrl.audio_mode_select && ctrl.sync_stop_select && !SYNC_DET && !soft_rst
         |=> DATA_ACTIVE == $past(DATA_ACTIVE))
      else $error("data flow changed between sync patterns");
   panic_stop_a: assert property (!ctrl.audio_mode_select && !ctrl.sync_stop_select |=> !DATA_ACTIVE)
      else $error("panic stop not immediate");
   audio_flow_a: assert property (ctrl.audio_mode_select && F1_CFLAG && !soft_rst
         |=> DATA_ACTIVE == $past(ctrl.audio_path_enable))
      else $error("audio flow not set by enable at F1 flag");
   audio_hold_a: assert property (ctrl.audio_mode_select && !F1_CFLAG && !soft_rst
         |=> $stable(DATA_ACTIVE))
      else $error("audio flow changed without F1 flag");
   ready_mirror_a: assert property (!soft_rst |=> COMBINED_READY == ($past(ctrl.audio_mode_select) ? $past(Q_FRAME_READY)
         : $past(hdr_valid)))
      else $error("combined ready does not mirror source");
   break_high_a: assert property (ctrl.uart_break |=> UART_TX_OUT)
      else $error("transmit output not held high in break");
   ffe_nostore_a: assert property (ctrl.forced_frame_end |=> !BUF_DATA.valid && !BUF_SUB.valid)
      else $error("data stored while frame-end forced");
   frame_reset_a: assert property (FRAME_RESET |-> $past(fell_ffe) && !$past(active))
      else $error("frame reset without inactive falling edge");
   search_hdr_a: assert property (searching && SYNC_DET && !fell_search && !soft_rst |=> hdr_valid
         && !SEARCH_ACTIVE)
      else $error("header not valid after sync found");
   wd_disable_a: assert property (ctrl.watchdog_service && wd_state == WD_RUN |=> wd_cnt == '0)
      else $error("watchdog counting while disabled");
   wd_pulse_a: assert property (CHIP_RESET && pulse_cnt == cfe_pkg::PULSE_CNT_W'(WD_PULSE_CYC - 1)
         |=> !CHIP_RESET)
      else $error("watchdog pulse has wrong length");
   wd_expire_a: assert property (wd_state == WD_RUN && !ctrl.watchdog_service && !fell_wd
         && wd_cnt == cfe_pkg::WD_CNT_W'(WD_PERIOD_CYC - 1) |=> CHIP_RESET)
      else $error("watchdog did not fire on expiry");
   search_start_a: assert property (fell_search && !soft_rst |=> SEARCH_ACTIVE)
      else $error("search not started on falling trigger");
   wd_ctrl_a: assert property (CHIP_RESET |=> ctrl == cfe_pkg::cfe_ctrl_t'(cfe_pkg::CTL_RESET) && !DATA_ACTIVE)
      else $error("control not reset by watchdog pulse");
   frame_pulse_a: assert property (fell_ffe && !active && !soft_rst |=> FRAME_RESET)
      else $error("frame reset missing after forced frame end");
   ffe_hold_a: assert property (ctrl.forced_frame_end |=> !FRAME_RESET)
      else $error("frame reset while forced frame end still high");
   uart_pass_a: assert property (!ctrl.uart_break |=> UART_TX_OUT == $past(UART_TX_IN))
      else $error("transmit output does not follow uart");

   data_run_c:  cover property (!ctrl.audio_mode_select && DATA_ACTIVE ##1 BUF_DATA.valid);
   audio_run_c: cover property (ctrl.audio_mode_select && DATA_ACTIVE);
   frame_rst_c: cover property (FRAME_RESET);
   wd_fire_c:   cover property ($rose(CHIP_RESET));
   search_c:    cover property (SEARCH_ACTIVE ##1 !SEARCH_ACTIVE);

endmodule

// file: testbench/cfe_decoder_model.sv
// decoder-side model: frame syncs, F1 C-flags, data and sub-code bytes, header, Q ready
`timescale 1ns/10ps
module cfe_decoder_model #(
   parameter int FRAME_CYC = 40
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // stream toward the block
   output logic               sync_det,
   output logic               f1_cflag,
   output cfe_pkg::cfe_byte_t data_out,
   output cfe_pkg::cfe_byte_t sub_out,
   output cfe_pkg::cfe_hdr_t  hdr_out,
   output logic               q_ready
);
   int cnt = 0;
   // ------------------------------------------------------------
   // frame timing: sync closes each frame, F1 flag in mid-frame
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cnt      <= (rst || cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
      sync_det <= !rst && cnt == FRAME_CYC - 1;
      f1_cflag <= !rst && cnt == FRAME_CYC / 2;
      // random gaps; an idle byte carries junk, not the last value
      data_out <= cfe_pkg::cfe_byte_t'({($urandom % 4) != 0, 8'($urandom)});
      sub_out  <= cfe_pkg::cfe_byte_t'({($urandom % 8) == 0, 8'($urandom)});
      if (rst) begin
         hdr_out <= '0;
         q_ready <= 1'b0;
      end else if (cnt == FRAME_CYC - 1) begin
         hdr_out <= cfe_pkg::cfe_hdr_t'($urandom);
         q_ready <= 1'($urandom);
      end
   end
endmodule

// file: testbench/cfe_front_end_ctrl_tb_top.sv
// self-checking bench of the front-end control block
`timescale 1ns/10ps
module cfe_front_end_ctrl_tb_top;
   localparam int          PER = 200;
   localparam int          PLS = 20;
   localparam logic [15:0] FEC = cfe_pkg::IDX_FRONT_END_CONTROL;
   localparam logic [15:0] IFR = cfe_pkg::IDX_INTERRUPT_FLAG;
   logic               CLK = 1'b0;
   logic               RESET = 1'b1;
   logic               CYC_I = 1'b0;
   logic               STB_I = 1'b0;
   logic               WE_I = 1'b0;
   logic               UART_TX_IN = 1'b1;
   logic [17:0]        ADR_I = '0;
   logic [3:0]         SEL_I = '0;
   logic [31:0]        DAT_I = '0;
   logic [31:0]        DAT_O;
   logic               ACK_O, SYNC_DET, F1_CFLAG, Q_FRAME_READY, FRAME_RESET, DATA_ACTIVE;
   logic               BIT_CLK_SHIFT, SEARCH_ACTIVE, COMBINED_READY, UART_TX_OUT, CHIP_RESET;
   cfe_pkg::cfe_byte_t DATA_IN, SUB_IN, BUF_DATA, BUF_SUB;
   cfe_pkg::cfe_hdr_t  HDR_IN;
   int                 n_errors = 0;
   int                 cmp_count = 0;
   int                 fr_cnt = 0;
   int                 k;
   logic [7:0]         rd;
   logic [31:0]        keep;

   always #12.5 CLK = ~CLK;
   always @(posedge CLK) UART_TX_IN <= 1'($urandom);
   always @(posedge CLK) if (FRAME_RESET === 1'b1) fr_cnt++;

   cfe_front_end_ctrl #(.WD_PERIOD_CYC(PER), .WD_PULSE_CYC(PLS)) dut (
      .CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
      .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .SYNC_DET(SYNC_DET),
      .F1_CFLAG(F1_CFLAG), .DATA_IN(DATA_IN), .SUB_IN(SUB_IN), .HDR_IN(HDR_IN),
      .Q_FRAME_READY(Q_FRAME_READY), .BUF_DATA(BUF_DATA), .BUF_SUB(BUF_SUB),
      .FRAME_RESET(FRAME_RESET), .DATA_ACTIVE(DATA_ACTIVE), .BIT_CLK_SHIFT(BIT_CLK_SHIFT),
      .SEARCH_ACTIVE(SEARCH_ACTIVE), .COMBINED_READY(COMBINED_READY), .UART_TX_IN(UART_TX_IN),
      .UART_TX_OUT(UART_TX_OUT), .CHIP_RESET(CHIP_RESET));
   cfe_decoder_model #(.FRAME_CYC(40)) model (
      .clk(CLK), .rst(RESET), .sync_det(SYNC_DET), .f1_cflag(F1_CFLAG), .data_out(DATA_IN),
      .sub_out(SUB_IN), .hdr_out(HDR_IN), .q_ready(Q_FRAME_READY));

   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge CLK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I  <= we;
      ADR_I <= {idx, 2'b00};
      SEL_I <= 4'h1;
      DAT_I <= {24'h0000_00, wd};
      do begin
         @(posedge CLK);
         n++;
      end while (ACK_O !== 1'b1 && n < 20);
      chk("bus ack", 1, ACK_O);
      rd = DAT_O[7:0];
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(what, {24'h0000_00, exp}, {24'h0000_00, rd});
   endtask
   // expected read status byte from the flag levels
   function automatic logic [7:0] exp_status(input logic act_on, input logic q, input logic hv, input logic srch);
      exp_status                         = 8'h00;
      exp_status[cfe_pkg::ST_ACTIVE_BIT] = act_on;
      exp_status[cfe_pkg::ST_QRDY_BIT]   = q;
      exp_status[cfe_pkg::ST_HDR_BIT]    = hv;
      exp_status[cfe_pkg::ST_SEARCH_BIT] = srch;
   endfunction
   // stop at the falling edge just before the event is sampled
   task automatic waitev(input bit f1);
      int n;
      n = 0;
      do begin
         @(negedge CLK);
         n++;
      end while ((f1 ? F1_CFLAG : SYNC_DET) !== 1'b1 && n < 200);
      chk("event seen", 1, n < 200);
   endtask
   task automatic act(input logic exp);
      @(negedge CLK);
      chk("data active", exp, DATA_ACTIVE);
   endtask
   task automatic wrap_up;
      $display("errors %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #500_000;
      n_errors++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hcc227fb8));
      repeat (4) @(posedge CLK);
      RESET <= 1'b0;
      rdchk("ctrl reset", FEC, 8'h03);
      rdchk("unmapped", 16'h0000, 8'h00);
      bus(1'b1, FEC, 8'h12);
      waitev(0);
      act(1);
      keep = 32'(DATA_IN);
      @(negedge CLK);
      chk("buf data", keep, 32'(BUF_DATA));
      bus(1'b1, FEC, 8'h92);
      // the byte stored at the write edge still belongs to the old setting
      @(negedge CLK);
      k = 0;
      repeat (8) begin
         @(negedge CLK);
         if (BUF_DATA.valid !== 1'b0 || BUF_SUB.valid !== 1'b0) k++;
      end
      chk("gated bytes", 0, k);
      fr_cnt = 0;
      bus(1'b1, FEC, 8'h12);
      repeat (4) @(negedge CLK);
      chk("frame reset busy", 0, fr_cnt);
      waitev(0);
      bus(1'b1, FEC, 8'h13);
      act(1);
      waitev(0);
      act(0);
      bus(1'b1, FEC, 8'h12);
      waitev(0);
      act(1);
      bus(1'b1, FEC, 8'h10);
      @(negedge CLK);
      act(0);
      waitev(0);
      act(0);
      fr_cnt = 0;
      bus(1'b1, FEC, 8'h90);
      bus(1'b1, FEC, 8'h10);
      repeat (4) @(negedge CLK);
      chk("frame reset", 1, fr_cnt);
      bus(1'b1, FEC, 8'h1c);
      @(negedge CLK);
      chk("bit clock shift", 1, BIT_CLK_SHIFT);
      waitev(1);
      act(1);
      keep[0] = Q_FRAME_READY;
      rdchk("combined ready audio", IFR, {7'h00, keep[0]});
      rdchk("status audio", cfe_pkg::IDX_READ_STATUS, exp_status(1'b1, keep[0], 1'b0, 1'b0));
      bus(1'b1, FEC, 8'h14);
      act(1);
      waitev(1);
      act(0);
      bus(1'b1, FEC, 8'h10);
      @(negedge CLK);
      chk("bit clock shift", 0, BIT_CLK_SHIFT);
      bus(1'b1, FEC, 8'h50);
      bus(1'b1, FEC, 8'h10);
      repeat (2) @(negedge CLK);
      chk("search", 1, SEARCH_ACTIVE);
      waitev(0);
      keep = 32'(HDR_IN);
      @(negedge CLK);
      chk("search done", 0, SEARCH_ACTIVE);
      rdchk("status search", cfe_pkg::IDX_READ_STATUS, exp_status(1'b0, Q_FRAME_READY, 1'b1, 1'b0));
      rdchk("combined ready data", IFR, 8'h01);
      @(negedge CLK);
      chk("combined ready pin", 1, COMBINED_READY);
      rdchk("hdr mode", cfe_pkg::IDX_HDR_MODE, keep[31:24]);
      rdchk("hdr minutes", cfe_pkg::IDX_HDR_MINUTES, keep[23:16]);
      rdchk("hdr seconds", cfe_pkg::IDX_HDR_SECONDS, keep[15:8]);
      rdchk("hdr frame", cfe_pkg::IDX_HDR_FRAME, keep[7:0]);
      rdchk("combined ready read", IFR, 8'h00);
      bus(1'b1, FEC, 8'h30);
      rdchk("ctrl readback", FEC, 8'h30);
      k = 0;
      repeat (8) begin
         @(negedge CLK);
         if (UART_TX_OUT !== 1'b1) k++;
      end
      chk("break", 0, k);
      bus(1'b1, FEC, 8'h10);
      @(negedge CLK);
      keep[0] = UART_TX_IN;
      @(negedge CLK);
      chk("uart pass", keep[0], UART_TX_OUT);
      k = 0;
      repeat (300) begin
         @(negedge CLK);
         if (CHIP_RESET !== 1'b0) k++;
      end
      chk("watchdog held", 0, k);
      bus(1'b1, FEC, 8'h00);
      k = 0;
      while (CHIP_RESET !== 1'b1 && k < 400) begin
         @(negedge CLK);
         k++;
      end
      chk("watchdog expiry", 1, k >= PER - 3 && k <= PER + 3);
      k = 0;
      while (CHIP_RESET === 1'b1 && k < 100) begin
         @(negedge CLK);
         k++;
      end
      chk("reset pulse", PLS, k);
      rdchk("ctrl after expiry", FEC, 8'h03);
      wrap_up();
   end
endmodule
